// ==== rtl/asp_pkg.sv ====
package asp_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] GPIO_DIR_OFS = 8'h04;
    localparam logic [7:0] GPIO_OUT_OFS = 8'h08;
    localparam logic [7:0] GPIO_IN_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] TX_BASE_OFS = 8'h20;
    localparam logic [7:0] RX_BASE_OFS = 8'h30;
    localparam logic [7:0] LANE_STRIDE = 8'h04;
    localparam logic [7:0] WORD_ADDR_MASK = 8'hFC;

    // Field positions inside the direction register
    localparam int GPIO_OE_LSB = 0;
    localparam int GPIO_IE_LSB = 8;

    // Pin indexes of the shared pin vector
    localparam int PIN_N = 6;
    localparam int PIN_RCK = 0;
    localparam int PIN_TCK = 1;
    localparam int PIN_FST = 2;
    localparam int PIN_LANE0 = 3;

    // Data lanes, word and frame shape
    localparam int LANE_N = 3;
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] SLOT_BITS = 6'h10;
    localparam logic [CNT_W-1:0] FRAME_LAST_NORMAL = 6'h0F;
    localparam logic [CNT_W-1:0] FRAME_LAST_NETWORK = 6'h1F;

    // Reset values
    localparam logic [5:0] PIN_RESET = 6'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    // Bit clock generated from the core clock when a clock pin drives
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_CLK_HALF_NS = 20;
    localparam int BIT_CLK_HALF_CYC =
        (BIT_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register, bit 0 at the bottom
    typedef struct packed {
        logic [LANE_N-1:0] lane_en;
        logic [LANE_N-1:0] lane_is_tx;
        logic network_mode;
        logic output_flag_zero;
        logic transmit_frame_sync_direction;
        logic transmit_clock_direction;
        logic receive_clock_direction;
        logic sync_select;
        logic iface_en;
    } asp_ctrl_t;

    localparam int CTRL_BITS = $bits(asp_ctrl_t);
    localparam asp_ctrl_t CTRL_RESET = '0;

    // Pin drive bundle: level and enable
    typedef struct packed {
        logic [PIN_N-1:0] oe;
        logic [PIN_N-1:0] dout;
    } asp_pins_t;

endpackage

// ==== rtl/asp_lane.sv ====
`timescale 1ns/1ps
// One data lane: transmit or receive shifting on the bit clock
module asp_lane import asp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic is_tx_in,
    input wire logic load_in,
    input wire logic [WORD_BITS-1:0] tx_word_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic [WORD_BITS-1:0] rx_word_out
);

    logic [WORD_BITS-1:0] shift; // Shared shift register, MSB first

    ////////////////////////////////////////////////////////////////////
    // Shift register: load at slot start, then one bit per clock
    always_ff @(posedge clk_in) begin
        if (rst_in || !enable_in) begin
            shift <= WORD_RESET;
            serial_out <= 1'b0;
        end else if (is_tx_in) begin
            // Transmit lane drives MSB first
            if (load_in) begin
                serial_out <= tx_word_in[WORD_BITS-1];
                shift <= {tx_word_in[WORD_BITS-2:0], 1'b0};
            end else begin
                serial_out <= shift[WORD_BITS-1];
                shift <= {shift[WORD_BITS-2:0], 1'b0};
            end
        end else begin
            // Receive lane; a load starts a fresh word
            serial_out <= 1'b0;
            if (load_in) begin
                shift <= {{(WORD_BITS-1){1'b0}}, serial_in};
            end else begin
                shift <= {shift[WORD_BITS-2:0], serial_in};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Completed word held stable for a whole slot for the core to read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_word_out <= WORD_RESET;
        end else if (enable_in && !is_tx_in && load_in) begin
            rx_word_out <= shift;
        end
    end

endmodule // asp_lane

// ==== rtl/asp_pin_route.sv ====
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Async: receive clock pin outputs the bit clock when set as output
// - Sync: receive clock pin becomes flag zero
// - Flag pin direction from receive clock direction
// - Output flag pin shows output flag bit
// - Flag output changes at frame or slot
// - Input flag sampled at frame or slot
// - Sync: transmit clock clocks all lanes
// - Async: transmit clock still clocks all lanes
// - General-purpose mode: per-pin in, out, off
// - Reset leaves every pin disconnected
// - Transmit lanes shift onto data pins
// - Receive lanes shift from data pins
// - Frame sync pin direction from its bit
module asp_pin_route import asp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_bit_clk_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [PIN_N-1:0] pin_in,
    output logic [PIN_N-1:0] pin_out,
    output logic [PIN_N-1:0] pin_oe_out
);

    ////////////////////////////////////////////////////////////////////
    // Core-domain state
    logic [7:0] aw_addr; // Captured write address
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb; // Captured byte enables
    logic do_write; // Both halves held, no response pending
    logic wr_mapped; // Write address hits a writable register
    logic [31:0] rd_mux; // Read data for the current read address
    logic rd_mapped; // Read address hits a register
    asp_ctrl_t ctrl; // Control register
    asp_ctrl_t next_ctrl; // Control after a byte-enabled write
    logic [PIN_N-1:0] gpio_oe; // General-purpose output enables
    logic [PIN_N-1:0] gpio_ie; // General-purpose input enables
    logic [PIN_N-1:0] gpio_dout; // General-purpose output levels
    logic [PIN_N-1:0] gin_s1; // Pin synchroniser, first stage
    logic [PIN_N-1:0] gin_s2; // Pin synchroniser, second stage
    logic if0_s1; // Input flag synchroniser, first stage
    logic if0_s2; // Input flag as seen by software
    logic [2:0] slot_sync; // Slot toggle sync chain plus history
    logic slot_ev; // One pulse per link slot start
    logic [DIV_W-1:0] div_cnt; // Bit clock divider count
    logic bclk; // Generated bit clock level
    asp_pins_t core_pins; // Pin drive owned by the core domain
    logic [PIN_N-1:0] use_link; // Pin drive handed to the link domain
    logic [WORD_BITS-1:0] tx_pend [LANE_N]; // Words written by software
    logic [WORD_BITS-1:0] tx_hold [LANE_N]; // Words offered to the link
    logic [WORD_BITS-1:0] rx_cap [LANE_N]; // Received words for software

    ////////////////////////////////////////////////////////////////////
    // Link-domain state
    logic lrst_s1; // Reset synchroniser, first stage
    logic lrst; // Reset inside the link domain
    asp_ctrl_t ctrl_s1; // Control synchroniser, first stage
    asp_ctrl_t lctrl; // Control as used on the bit clock
    logic [PIN_N-1:0] lpin_s1; // Pin synchroniser, first stage
    logic [PIN_N-1:0] lpin; // Pins as sampled on the bit clock
    logic fs_prev; // Previous external frame sync level
    logic [CNT_W-1:0] bit_cnt; // Bit position in the frame
    logic [CNT_W-1:0] next_bit_cnt; // Position at the next bit
    logic [CNT_W-1:0] frame_last; // Last bit position of a frame
    logic frame_start; // First bit of a frame
    logic slot_start; // First bit of a slot
    logic slot_tgl; // Toggles once per slot start
    logic if0_link; // Input flag captured at a boundary
    logic of0_link; // Output flag level held between boundaries
    asp_pins_t link_pins; // Pin drive owned by the link domain
    logic [LANE_N-1:0] lane_sdo; // Serial outputs of the lanes
    logic [WORD_BITS-1:0] lane_rx [LANE_N]; // Lane receive words

    ////////////////////////////////////////////////////////////////////
    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old_val,
            input logic [31:0] new_val, input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Write channels: address and data taken in either order
    assign do_write = !s_axi_awready_out && !s_axi_wready_out &&
        !s_axi_bvalid_out;
    assign wr_mapped = (aw_addr == CTRL_OFS) ||
        (aw_addr == GPIO_DIR_OFS) || (aw_addr == GPIO_OUT_OFS) ||
        ((aw_addr & WORD_ADDR_MASK) >= TX_BASE_OFS &&
         (aw_addr & WORD_ADDR_MASK) < TX_BASE_OFS + 8'h0C &&
         aw_addr[1:0] == 2'h0);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            // Response one cycle after both halves are held
            if (do_write) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            // Reopen both channels only once the response is taken
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control and general-purpose registers
    assign next_ctrl = asp_ctrl_t'(CTRL_BITS'(merge(32'(ctrl), w_data,
        w_strb)));
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl <= CTRL_RESET;
            gpio_oe <= PIN_RESET;
            gpio_ie <= PIN_RESET;
            gpio_dout <= PIN_RESET;
        end else if (do_write) begin
            if (aw_addr == CTRL_OFS) begin
                ctrl <= next_ctrl;
            end
            if (aw_addr == GPIO_DIR_OFS) begin
                gpio_oe <= PIN_N'(merge({16'h0000, 2'h0, gpio_ie,
                    2'h0, gpio_oe}, w_data, w_strb) >> GPIO_OE_LSB);
                gpio_ie <= PIN_N'(merge({16'h0000, 2'h0, gpio_ie,
                    2'h0, gpio_oe}, w_data, w_strb) >> GPIO_IE_LSB);
            end
            if (aw_addr == GPIO_OUT_OFS) begin
                gpio_dout <= PIN_N'(merge(32'(gpio_dout), w_data,
                    w_strb));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data selection; unmapped addresses answer with an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (s_axi_araddr_in)
            CTRL_OFS: rd_mux = 32'(ctrl);
            GPIO_DIR_OFS: rd_mux = {16'h0000, 2'h0, gpio_ie, 2'h0, gpio_oe};
            GPIO_OUT_OFS: rd_mux = 32'(gpio_dout);
            GPIO_IN_OFS: rd_mux = 32'(gin_s2 & gpio_ie);
            STATUS_OFS: rd_mux = 32'(if0_s2);
            default: begin
                rd_mapped = 1'b0;
                for (int k = 0; k < LANE_N; k++) begin
                    if (s_axi_araddr_in == TX_BASE_OFS +
                            8'(k) * LANE_STRIDE) begin
                        rd_mux = 32'(tx_pend[k]);
                        rd_mapped = 1'b1;
                    end
                    if (s_axi_araddr_in == RX_BASE_OFS +
                            8'(k) * LANE_STRIDE) begin
                        rd_mux = 32'(rx_cap[k]);
                        rd_mapped = 1'b1;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_mux;
            s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin and flag synchronisers into the core domain
    always_ff @(posedge clk_in) begin
        gin_s1 <= pin_in;
        gin_s2 <= gin_s1;
        if0_s1 <= if0_link;
        if0_s2 <= if0_s1;
    end

    ////////////////////////////////////////////////////////////////////
    // Slot event from the link: toggle, two flops, then edge detect
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            slot_sync <= 3'h0;
        end else begin
            slot_sync <= {slot_sync[1:0], slot_tgl};
        end
    end
    assign slot_ev = slot_sync[2] ^ slot_sync[1];

    ////////////////////////////////////////////////////////////////////
    // Bit clock divider for clock pins set as outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_cnt <= '0;
            bclk <= 1'b0;
        end else if (div_cnt == DIV_W'(BIT_CLK_HALF_CYC - 1)) begin
            div_cnt <= '0;
            bclk <= !bclk;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core-owned pin drive: general-purpose pins and bit clock pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            core_pins <= '0;
            use_link <= PIN_RESET;
        end else if (!ctrl.iface_en) begin
            // Disconnected unless the pin is enabled as an output
            core_pins.oe <= gpio_oe;
            core_pins.dout <= gpio_dout & gpio_oe;
            use_link <= PIN_RESET;
        end else begin
            core_pins.oe <= PIN_RESET;
            core_pins.dout <= PIN_RESET;
            // Transmit clock pin: clock for the whole link
            core_pins.oe[PIN_TCK] <= ctrl.transmit_clock_direction;
            core_pins.dout[PIN_TCK] <= bclk;
            // Receive clock pin is a clock only when not synchronous
            if (!ctrl.sync_select) begin
                core_pins.oe[PIN_RCK] <= ctrl.receive_clock_direction;
                core_pins.dout[PIN_RCK] <= bclk;
            end
            use_link <= PIN_RESET;
            use_link[PIN_RCK] <= ctrl.sync_select;
            use_link[PIN_FST] <= 1'b1;
            use_link[PIN_N-1:PIN_LANE0] <= {LANE_N{1'b1}};
        end
    end

    // Each pin is driven by whichever domain currently owns it
    assign pin_out = (use_link & link_pins.dout) |
        (~use_link & core_pins.dout);
    assign pin_oe_out = (use_link & link_pins.oe) |
        (~use_link & core_pins.oe);

    ////////////////////////////////////////////////////////////////////
    // Reset, control and pin synchronisers into the link domain
    always_ff @(posedge link_bit_clk_in) begin
        lrst_s1 <= rst_in;
        lrst <= lrst_s1;
        ctrl_s1 <= ctrl;
        lctrl <= ctrl_s1;
        lpin_s1 <= pin_in;
        lpin <= lpin_s1;
    end

    ////////////////////////////////////////////////////////////////////
    // Frame and slot timing on the bit clock
    assign frame_last = lctrl.network_mode ? FRAME_LAST_NETWORK :
        FRAME_LAST_NORMAL;
    always_comb begin
        if (!lctrl.iface_en) begin
            frame_start = 1'b0;
        end else if (lctrl.transmit_frame_sync_direction) begin
            frame_start = (bit_cnt == '0);
        end else begin
            frame_start = lpin[PIN_FST] && !fs_prev;
        end
        slot_start = frame_start || (lctrl.iface_en &&
            lctrl.network_mode && bit_cnt == SLOT_BITS);
        if (frame_start) begin
            next_bit_cnt = CNT_W'(1);
        end else if (bit_cnt >= frame_last) begin
            next_bit_cnt = '0;
        end else begin
            next_bit_cnt = bit_cnt + CNT_W'(1);
        end
    end

    // Counter relies on a bit clock that keeps running while enabled
    always_ff @(posedge link_bit_clk_in) begin
        if (lrst || !lctrl.iface_en) begin
            bit_cnt <= '0;
            fs_prev <= 1'b0;
            slot_tgl <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            fs_prev <= lpin[PIN_FST];
            slot_tgl <= slot_tgl ^ slot_start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial flag zero, moved only at frame or slot boundaries
    always_ff @(posedge link_bit_clk_in) begin
        if (lrst) begin
            of0_link <= 1'b0;
            if0_link <= 1'b0;
        end else if (slot_start && lctrl.sync_select) begin
            if (lctrl.receive_clock_direction) begin
                of0_link <= lctrl.output_flag_zero;
            end else begin
                if0_link <= lpin[PIN_RCK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link-owned pin drive: flag, frame sync and data lanes
    always_ff @(posedge link_bit_clk_in) begin
        if (lrst) begin
            link_pins.oe <= PIN_RESET;
            link_pins.dout <= PIN_RESET;
        end else begin
            link_pins.dout[PIN_RCK] <= of0_link;
            link_pins.oe[PIN_RCK] <= lctrl.iface_en &&
                lctrl.sync_select && lctrl.receive_clock_direction;
            link_pins.oe[PIN_TCK] <= 1'b0;
            link_pins.oe[PIN_FST] <= lctrl.iface_en &&
                lctrl.transmit_frame_sync_direction;
            link_pins.dout[PIN_TCK] <= 1'b0;
            link_pins.dout[PIN_FST] <= lctrl.iface_en &&
                lctrl.transmit_frame_sync_direction &&
                next_bit_cnt == '0;
            // A shared data pin drives only for a transmit lane
            link_pins.oe[PIN_N-1:PIN_LANE0] <= {LANE_N{lctrl.iface_en}} &
                lctrl.lane_en & lctrl.lane_is_tx;
            link_pins.dout[PIN_N-1:PIN_LANE0] <= lane_sdo;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-lane words and shifters; lane i is either a transmit or a
    // receive lane on one pin. Words cross once per slot: the core
    // moves the held word just after a slot start, and the link only
    // reads it at the next one, so it is stable when sampled.
    for (genvar i = 0; i < LANE_N; i++) begin : g_lane
        localparam logic [7:0] TX_ADDR = TX_BASE_OFS +
            8'(i) * LANE_STRIDE;

        // Software word, taken over at each slot event
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                tx_pend[i] <= WORD_RESET;
                tx_hold[i] <= WORD_RESET;
                rx_cap[i] <= WORD_RESET;
            end else begin
                if (do_write && aw_addr == TX_ADDR) begin
                    tx_pend[i] <= WORD_BITS'(merge(32'(tx_pend[i]),
                        w_data, w_strb));
                end
                if (slot_ev) begin
                    tx_hold[i] <= tx_pend[i];
                    rx_cap[i] <= lane_rx[i];
                end
            end
        end

        // Every lane shifts on the one link bit clock
        asp_lane u_lane (
            .clk_in(link_bit_clk_in),
            .rst_in(lrst),
            .enable_in(lctrl.iface_en && lctrl.lane_en[i]),
            .is_tx_in(lctrl.lane_is_tx[i]),
            .load_in(slot_start),
            .tx_word_in(tx_hold[i]),
            .serial_in(lpin[PIN_LANE0 + i]),
            .serial_out(lane_sdo[i]),
            .rx_word_out(lane_rx[i])
        );
    end

endmodule // asp_pin_route

// ==== testbench/asp_pin_route_properties.sv ====
`timescale 1ns/1ps
// Bus handshake and pin checks, bound to the routing block
module asp_pin_route_properties import asp_pkg::*; (
    input wire logic clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in,
    input wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out,
    input wire logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out,
    input wire logic s_axi_rvalid_out, s_axi_rready_in,
    input wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [PIN_N-1:0] pin_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    pins_off_a: assert property ($fell(rst_in) |-> pin_oe_out == '0)
        else $error("pin driven after reset");
    write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
        else $error("write answer late");
    resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write answer dropped");
    write_busy_a: assert property (s_axi_bvalid_out
        |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while busy");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out) else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read answer dropped");
    read_busy_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken while busy");
    refused_zero_a: assert property (s_axi_rvalid_out
        && s_axi_rresp_out == RESP_SLVERR |-> s_axi_rdata_out == '0)
        else $error("refused read gave data");
endmodule // asp_pin_route_properties

// ==== testbench/asp_codec_model.sv ====
`timescale 1ns/1ps
// Far-side codec; pins the device leaves undriven take the codec's levels
module asp_codec_model import asp_pkg::*; (
    input wire logic run_in,
    input wire logic flag_in,
    input wire logic data_in,
    input wire logic [PIN_N-1:0] drv_in,
    input wire logic [PIN_N-1:0] oe_in,
    output logic [PIN_N-1:0] wire_out
);
    logic bclk = 1'b0; // Codec bit clock, parked low when idle
    always #16 bclk = run_in ? ~bclk : 1'b0;
    // Device wins wherever it drives
    always_comb begin
        wire_out = {{3{data_in}}, 1'b0, bclk, flag_in};
        wire_out = (wire_out & ~oe_in) | (drv_in & oe_in);
    end
endmodule // asp_codec_model

// ==== testbench/asp_pin_route_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %0h got %0h", nm, e, a); end end
module asp_pin_route_tb_top import asp_pkg::*; ;
    logic clk_in = 1'b0, rst_in = 1'b1, run = 1'b1, flag = 1'b0;
    logic sdata = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
    logic s_axi_rready_in = 1'b0, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rdat, v;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
    logic [PIN_N-1:0] pin_in, pin_out, pin_oe_out;
    wire logic link_bit_clk_in;
    int mismatches = 0, checks = 0, seed = 20556, n;
    always #5 clk_in = ~clk_in;
    assign link_bit_clk_in = pin_in[PIN_TCK];
    asp_pin_route dut (.*);
    asp_codec_model codec (.run_in(run), .flag_in(flag), .data_in(sdata),
        .drv_in(pin_out), .oe_in(pin_oe_out), .wire_out(pin_in));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo;
        if (n >= 99) begin
            mismatches++;
            stop_test();
        end
    endtask
    // Late ready, so the answer must stand for one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        n = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out && n < 99);
        tmo();
        s_axi_bready_in <= 1'b1;
        @(posedge clk_in);
        rs = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        n = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out && n < 99);
        tmo();
        s_axi_rready_in <= 1'b1;
        @(posedge clk_in);
        rdat = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask
    initial begin
        // Codec clock keeps running so the link reset clears cleanly
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        `CHK("pin_oe", 6'h00, pin_oe_out)
        rd(8'h40);
        `CHK("bad_read", RESP_SLVERR, rs)
        wr(STATUS_OFS, 32'h1);
        `CHK("ro_write", RESP_SLVERR, rs)
        repeat (4) begin
            v = $random(seed);
            wr(GPIO_DIR_OFS, {26'h0, v[5:0]});
            wr(GPIO_OUT_OFS, {26'h0, v[13:8]});
            repeat (4) @(posedge clk_in);
            `CHK("gpio_oe", v[5:0], pin_oe_out)
            `CHK("gpio_out", v[13:8] & v[5:0], pin_out & v[5:0])
            rd(GPIO_IN_OFS);
            `CHK("gpio_in", 32'h0, rdat)
        end
        $display("general-purpose test done");
        wr(CTRL_OFS, 32'h3F);
        repeat (200) @(posedge clk_in);
        `CHK("flag_oe", 1'b1, pin_oe_out[PIN_RCK])
        `CHK("flag_out", 1'b1, pin_out[PIN_RCK])
        `CHK("tck_oe", 1'b1, pin_oe_out[PIN_TCK])
        `CHK("fs_oe", 1'b1, pin_oe_out[PIN_FST])
        flag <= 1'b1;
        wr(CTRL_OFS, 32'h1B);
        repeat (200) @(posedge clk_in);
        `CHK("flag_in_oe", 1'b0, pin_oe_out[PIN_RCK])
        rd(STATUS_OFS);
        `CHK("flag_in", 32'h1, rdat)
        $display("flag test done");
        // Pair 0 sends, pair 1 listens, codec makes the bit clock
        wr(CTRL_OFS, 32'hC91);
        for (int k = 0; k < 2; k++) begin
            v = k ? 32'h0 : 32'hFFFF;
            sdata <= ~k[0];
            wr(TX_BASE_OFS, v);
            repeat (400) @(posedge clk_in);
            `CHK("tx_oe", 1'b1, pin_oe_out[PIN_LANE0])
            `CHK("rx_oe", 1'b0, pin_oe_out[PIN_LANE0+1])
            `CHK("rck_oe", 1'b0, pin_oe_out[PIN_RCK])
            `CHK("sdo", v[0], pin_out[PIN_LANE0])
            rd(RX_BASE_OFS + LANE_STRIDE);
            `CHK("rx_word", v, rdat)
        end
        $display("lane test done");
        stop_test();
    end
endmodule // asp_pin_route_tb_top
bind asp_pin_route asp_pin_route_properties chk (.*);
